// ===== hw/clock_gen_event_defs.svh
`ifndef CLOCK_GEN_EVENT_DEFS_SVH
`define CLOCK_GEN_EVENT_DEFS_SVH

// register offsets
`define OFF_IDENTITY      8'h00
`define OFF_REF_STATUS    8'h02
`define OFF_LOOP_STATUS   8'h03
`define OFF_REF_MASK      8'h04
`define OFF_LOOP_MASK     8'h05
`define OFF_RAW_MON       8'h07
`define OFF_IND_MASK      8'h09
`define OFF_REVISION_HI   8'hC6
`define OFF_GPIO_SEL      8'hE8

// reset values
`define RST_REF_MASK      8'h00
`define RST_LOOP_MASK     8'h00
`define RST_IND_MASK      8'h66
`define RST_REVISION_HI   8'h03
`define RST_GPIO_SEL      8'h10

// identity field positions
`define ID_PART_LSB       0
`define ID_REV_LSB        5
`define ID_READY_BIT      7

// loop status bit positions
`define LOOP_HOLDOVER_BIT 0
`define LOOP_UNLOCK_BIT   1

// raw monitor: four indicators per input, input 1 starts at bit 4
`define MON_PER_INPUT     4
`define MON_SIGNAL_ABSENT 0
`define MON_SINGLE_PERIOD 1
`define MON_ROUGH_RATE    2
`define MON_SOAK_TIMER    3

// readiness timing: ready within 50 ms, host waits 40 ms
`define READY_MAX_MS      50
`define HOST_WAIT_MS      40
`define CLK_HZ            40000000
`define INIT_MS           45

`endif

// ===== hw/clock_gen_event_pkg.sv
`default_nettype none

package clock_gen_event_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic signal_absent;
    logic single_period;
    logic rough_rate;
    logic soak_timer;
  } monitor_t;

  typedef enum logic [1:0] {
    ST_INIT  = 2'b01,
    ST_READY = 2'b10
  } init_state_t;

endpackage : clock_gen_event_pkg

`default_nettype wire

// ===== hw/clock_gen_event_status_regs.sv
// Overview of operation
// - ready bit, identity bit 7, goes high after internal initialisation
// - ready rises no later than 50 ms after reset release
// - identity holds part code 4:0, low revision 6:5; high revision at 0xC6
// - reference 0 failure sets status bit 0 when its mask bit set
// - any set status bit drives interrupt request high
// - reference 1 failure sets status bit 1 under its own mask
// - holdover sets loop status bit 0 when holdover mask set
// - loss of lock sets loop status bit 1 when unlock mask set
// - reference mask zero blocks recording and interrupt
// - loop mask zero blocks recording and interrupt
// - external signal-absent input latches its raw indicator
// - signal-absent input taken from any selectable general pin
// - single-period failure latches its raw indicator
// - rough rate failure latches its raw indicator
// - soak timer expiry latches its raw indicator
// - raw indicators latch regardless of any mask
// - raw register: input 0 in bits 3:0, input 1 in bits 7:4
// - indicator mask at 0x09 selects contributors, raw register unaffected
//
// The strobed register port is this design's own decision.
`include "clock_gen_event_defs.svh"
`default_nettype none

module clock_gen_event_status_regs #(
  parameter int GPIO_PINS = 7,
  parameter int INIT_MS   = `INIT_MS,
  parameter int CLK_HZ    = `CLK_HZ,
  parameter logic [4:0] PART_CODE = 5'h15, // arbitrary value
  parameter logic [1:0] REV_LOW   = 2'h1   // arbitrary value
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rstn,
  input  wire clock_gen_event_pkg::reg_req_t   reg_req,
  output logic [7:0]                           reg_rdata,
  input  wire logic [GPIO_PINS-1:0]            gpio_in,
  input  wire clock_gen_event_pkg::monitor_t   input0_mon,
  input  wire clock_gen_event_pkg::monitor_t   input1_mon,
  input  wire logic                            loop_holdover,
  input  wire logic                            loop_unlock_event,
  output logic                                 irq
);

  localparam int INIT_CYCLES = (CLK_HZ / 1000) * INIT_MS;
  localparam int MAX_CYCLES  = (CLK_HZ / 1000) * `READY_MAX_MS;
  localparam int CW          = $clog2(INIT_CYCLES + 1);

  // the 3-bit pin selects cannot reach more than eight pins
  if (GPIO_PINS < 1 || GPIO_PINS > 8) begin : g_bad_pins
    $error("GPIO_PINS must be 1..8");
  end
  // a longer start-up would break the ready promise
  if (INIT_CYCLES < 1 || INIT_CYCLES > MAX_CYCLES) begin : g_bad_init
    $error("INIT_MS must give 1 cycle up to the 50 ms bound");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic [3:0] pack_mon(
    input clock_gen_event_pkg::monitor_t m);
    pack_mon = {m.soak_timer, m.rough_rate, m.single_period,
                m.signal_absent};
  endfunction : pack_mon

  logic [7:0] addr;
  logic       wr;
  logic       rd;
  assign addr = reg_req.addr;
  assign wr   = reg_req.wr;
  assign rd   = reg_req.rd;

  // ---------------- initialisation / ready ----------------
  clock_gen_event_pkg::init_state_t state_q;
  logic [CW-1:0]                    init_cnt_q;
  logic                             init_done;

  // the counter stops at its end value so it never wraps back
  assign init_done = (init_cnt_q == CW'(INIT_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= clock_gen_event_pkg::ST_INIT;
    end else begin
      case (state_q)
        clock_gen_event_pkg::ST_INIT: begin
          if (init_done) begin
            state_q <= clock_gen_event_pkg::ST_READY;
          end
        end
        clock_gen_event_pkg::ST_READY: begin
          state_q <= clock_gen_event_pkg::ST_READY;
        end
        default: begin
          state_q <= clock_gen_event_pkg::ST_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      init_cnt_q <= '0;
    end else if (state_q == clock_gen_event_pkg::ST_INIT && !init_done) begin
      init_cnt_q <= init_cnt_q + CW'(1);
    end
  end

  logic ready;
  assign ready = (state_q == clock_gen_event_pkg::ST_READY);

  // ---------------- writable registers ----------------
  logic [7:0] ref_mask_q;
  logic [7:0] loop_mask_q;
  logic [7:0] ind_mask_q;
  logic [7:0] gpio_sel_q;
  logic       ref_mask_we;
  logic       loop_mask_we;
  logic       ind_mask_we;
  logic       gpio_sel_we;

  assign ref_mask_we  = wr && hit(addr, `OFF_REF_MASK);
  assign loop_mask_we = wr && hit(addr, `OFF_LOOP_MASK);
  assign ind_mask_we  = wr && hit(addr, `OFF_IND_MASK);
  assign gpio_sel_we  = wr && hit(addr, `OFF_GPIO_SEL);

  // reference mask; reserved bits kept zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_mask_q <= `RST_REF_MASK;
    end else if (ref_mask_we) begin
      ref_mask_q <= {6'h0, reg_req.wdata[1:0]};
    end
  end

  // loop mask; reserved bits kept zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      loop_mask_q <= `RST_LOOP_MASK;
    end else if (loop_mask_we) begin
      loop_mask_q <= {6'h0, reg_req.wdata[1:0]};
    end
  end

  // indicator mask, all eight bits live
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ind_mask_q <= `RST_IND_MASK;
    end else if (ind_mask_we) begin
      ind_mask_q <= reg_req.wdata;
    end
  end

  // pin select; bits 3 and 7 unused
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gpio_sel_q <= `RST_GPIO_SEL;
    end else if (gpio_sel_we) begin
      gpio_sel_q <= {1'b0, reg_req.wdata[6:4], 1'b0, reg_req.wdata[2:0]};
    end
  end

  // ---------------- pin synchronisers ----------------
  // three stages; a change counts once stages two and three agree
  logic [GPIO_PINS-1:0] gp_s1_q;
  logic [GPIO_PINS-1:0] gp_s2_q;
  logic [GPIO_PINS-1:0] gp_s3_q;
  logic [GPIO_PINS-1:0] gp_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gp_s1_q <= '0;
      gp_s2_q <= '0;
      gp_s3_q <= '0;
      gp_q    <= '0;
    end else begin
      gp_s1_q <= gpio_in;
      gp_s2_q <= gp_s1_q;
      gp_s3_q <= gp_s2_q;
      gp_q    <= (gp_s2_q & gp_s3_q) | (gp_q & (gp_s2_q | gp_s3_q));
    end
  end

  logic [2:0] sel0;
  logic [2:0] sel1;
  logic       los0;
  logic       los1;
  assign sel0 = gpio_sel_q[2:0];
  assign sel1 = gpio_sel_q[6:4];
  assign los0 = (int'(sel0) < GPIO_PINS) ? gp_q[sel0] : 1'b0;
  assign los1 = (int'(sel1) < GPIO_PINS) ? gp_q[sel1] : 1'b0;

  // ---------------- raw monitor register ----------------
  // bit layout per input
  logic [7:0] raw_in;
  assign raw_in = {pack_mon(input1_mon) | {3'b000, los1},
                   pack_mon(input0_mon) | {3'b000, los0}};

  logic [3:0] raw0_q;
  logic [3:0] raw1_q;
  logic [7:0] raw_word;
  logic       raw_rd;
  assign raw_rd   = rd && hit(addr, `OFF_RAW_MON);
  assign raw_word = {raw1_q, raw0_q};

  // input 0 nibble, unmasked, set wins over clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      raw0_q <= 4'h0;
    end else begin
      raw0_q <= (raw_rd ? 4'h0 : raw0_q) | raw_in[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      raw1_q <= 4'h0;
    end else begin
      raw1_q <= (raw_rd ? 4'h0 : raw1_q) | raw_in[7:4];
    end
  end

  // ---------------- reference failure status ----------------
  // indicator mask chooses contributors
  logic [1:0] ref_fail;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      assign ref_fail[gi] =
        |(raw_in[gi*`MON_PER_INPUT +: `MON_PER_INPUT] &
          ind_mask_q[gi*`MON_PER_INPUT +: `MON_PER_INPUT]);
    end
  endgenerate

  logic       ref0_stat_q;
  logic       ref1_stat_q;
  logic [1:0] ref_stat;
  logic       ref_rd;
  assign ref_rd   = rd && hit(addr, `OFF_REF_STATUS);
  assign ref_stat = {ref1_stat_q, ref0_stat_q};

  // input 0 sticky bit; a set in the read cycle survives
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref0_stat_q <= 1'b0;
    end else begin
      ref0_stat_q <= (ref0_stat_q & ~ref_rd) | (ref_fail[0] & ref_mask_q[0]);
    end
  end

  // input 1 sticky bit, same scheme
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref1_stat_q <= 1'b0;
    end else begin
      ref1_stat_q <= (ref1_stat_q & ~ref_rd) | (ref_fail[1] & ref_mask_q[1]);
    end
  end

  // ---------------- loop event status ----------------
  logic [1:0] loop_ev;
  logic       hold_stat_q;
  logic       unlock_stat_q;
  logic [1:0] loop_stat;
  logic       loop_rd;
  assign loop_ev[`LOOP_HOLDOVER_BIT] = loop_holdover;
  assign loop_ev[`LOOP_UNLOCK_BIT]   = loop_unlock_event;
  assign loop_rd = rd && hit(addr, `OFF_LOOP_STATUS);
  assign loop_stat[`LOOP_HOLDOVER_BIT] = hold_stat_q;
  assign loop_stat[`LOOP_UNLOCK_BIT]   = unlock_stat_q;

  // holdover sticky bit, read clears, set wins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hold_stat_q <= 1'b0;
    end else begin
      hold_stat_q <= (hold_stat_q & ~loop_rd) |
                     (loop_ev[`LOOP_HOLDOVER_BIT] &
                      loop_mask_q[`LOOP_HOLDOVER_BIT]);
    end
  end

  // loss of lock sticky bit, same scheme
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      unlock_stat_q <= 1'b0;
    end else begin
      unlock_stat_q <= (unlock_stat_q & ~loop_rd) |
                       (loop_ev[`LOOP_UNLOCK_BIT] &
                        loop_mask_q[`LOOP_UNLOCK_BIT]);
    end
  end

  // interrupt request
  // registered so the line never glitches while status bits change;
  // it follows the status one cycle late
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|ref_stat) | (|loop_stat);
    end
  end

  // ---------------- read data ----------------
  logic [7:0] rdata_d;

  // read mux; reserved and unmapped read zero
  always_comb begin
    rdata_d = 8'h00;
    case (addr)
      `OFF_IDENTITY:    rdata_d = {ready, REV_LOW, PART_CODE};
      `OFF_REF_STATUS:  rdata_d = {6'h00, ref_stat};
      `OFF_LOOP_STATUS: rdata_d = {6'h00, loop_stat};
      `OFF_REF_MASK:    rdata_d = ref_mask_q;
      `OFF_LOOP_MASK:   rdata_d = loop_mask_q;
      `OFF_RAW_MON:     rdata_d = raw_word;
      `OFF_IND_MASK:    rdata_d = ind_mask_q;
      `OFF_REVISION_HI: rdata_d = `RST_REVISION_HI;
      `OFF_GPIO_SEL:    rdata_d = gpio_sel_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : clock_gen_event_status_regs

`default_nettype wire

// ===== dv/status_regs_chk.sv
`default_nettype none
module status_regs_chk #(
  parameter int         CLK_HZ    = 1000,
  parameter logic [4:0] PART_CODE = 5'h0A,
  parameter logic [1:0] REV_LOW   = 2'h2
) (
  input wire logic                          ref_clk,
  input wire logic                          rstn,
  input wire clock_gen_event_pkg::reg_req_t reg_req,
  input wire logic [7:0]                    reg_rdata,
  input wire clock_gen_event_pkg::monitor_t input0_mon,
  input wire clock_gen_event_pkg::monitor_t input1_mon,
  input wire logic                          loop_holdover,
  input wire logic                          loop_unlock_event,
  input wire logic                          irq
);
  localparam int READY_CYC = 50 * CLK_HZ / 1000;
  logic [1:0] loop_mask_q;
  int         age_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // the loop mask is not a port, so it is shadowed from bus writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) loop_mask_q <= 2'h0;
    else if (reg_req.wr && reg_req.addr == 8'h05)
      loop_mask_q <= reg_req.wdata[1:0];
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) age_q <= 0;
    else if (age_q < 1000) age_q <= age_q + 1;
  end
  sequence s_rough0_read;
    input0_mon.rough_rate ##1 (reg_req.rd && reg_req.addr == 8'h07);
  endsequence
  sequence s_soak1_read;
    input1_mon.soak_timer ##1 (reg_req.rd && reg_req.addr == 8'h07);
  endsequence
  sequence s_quiet_reads;
    (reg_req.rd && reg_req.addr == 8'h03 && !loop_holdover &&
     !loop_unlock_event) ##1 (reg_req.rd && reg_req.addr == 8'h03);
  endsequence
  a_holdover_irq: assert property (
    loop_holdover && loop_mask_q[0] |-> ##2 irq) else $error("no irq");
  a_unlock_irq: assert property (
    loop_unlock_event && loop_mask_q[1] |-> ##2 irq) else $error("no irq");
  a_rdata_idle: assert property (
    !$past(reg_req.rd) |-> reg_rdata == 8'h00) else $error("rdata");
  a_ready_set: assert property (
    reg_req.rd && reg_req.addr == 8'h00 && age_q >= READY_CYC
    |=> reg_rdata[7]) else $error("not ready");
  a_id_fields: assert property (
    reg_req.rd && reg_req.addr == 8'h00
    |=> reg_rdata[6:0] == {REV_LOW, PART_CODE}) else $error("id");
  a_rsvd_zero: assert property (
    reg_req.rd && reg_req.addr inside {[8'h02:8'h05]}
    |=> reg_rdata[7:2] == 6'h00) else $error("reserved");
  a_raw_in0: assert property (
    s_rough0_read |=> reg_rdata[2]) else $error("raw input0");
  a_raw_in1: assert property (
    s_soak1_read |=> reg_rdata[7]) else $error("raw input1");
  a_read_clears: assert property (
    s_quiet_reads |=> reg_rdata == 8'h00) else $error("not cleared");
endmodule : status_regs_chk
`default_nettype wire

// ===== dv/host_model.sv
`default_nettype none
module host_model (
  input  wire logic                        ref_clk,
  output var clock_gen_event_pkg::reg_req_t reg_req,
  input  wire logic [7:0]                  reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req = '0;
  // callers enter just after an edge; the strobe lasts one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask : rd
  // ready is not looked at before 40 ms
  task automatic settle();
    repeat (40) @(posedge ref_clk);
    #1;
  endtask : settle
endmodule : host_model
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, a); \
end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PART = 5'h0A; // arbitrary value
  localparam logic [1:0] REV  = 2'h2;  // arbitrary value
  logic                          ref_clk           = 1'b0;
  logic                          rstn              = 1'b0;
  logic [6:0]                    gpio_in           = 7'h00;
  clock_gen_event_pkg::monitor_t input0_mon        = '0;
  clock_gen_event_pkg::monitor_t input1_mon        = '0;
  logic                          loop_holdover     = 1'b0;
  logic                          loop_unlock_event = 1'b0;
  clock_gen_event_pkg::reg_req_t reg_req;
  logic [7:0]                    reg_rdata;
  logic                          irq;
  logic [7:0]                    d;
  int                            compares          = 0;
  int                            miscompares       = 0;
  always #12.5 ref_clk = ~ref_clk;
  host_model u_host (.ref_clk, .reg_req, .reg_rdata);
  clock_gen_event_status_regs #(.CLK_HZ(1000), .INIT_MS(5),
    .PART_CODE(PART), .REV_LOW(REV)) u_dut (.ref_clk, .rstn, .reg_req,
    .reg_rdata, .gpio_in, .input0_mon, .input1_mon, .loop_holdover,
    .loop_unlock_event, .irq);
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic rdc(input logic [7:0] a, e, input string n);
    u_host.rd(a, d);
    `CHK(n, e, d)
  endtask : rdc
  // monitor nibbles: signal_absent, single_period, rough_rate, soak_timer
  task automatic pulse(input logic [3:0] a0, a1, input logic h, u);
    input0_mon <= a0;
    input1_mon <= a1;
    loop_holdover <= h;
    loop_unlock_event <= u;
    @(posedge ref_clk);
    input0_mon <= '0;
    input1_mon <= '0;
    loop_holdover <= 1'b0;
    loop_unlock_event <= 1'b0;
  endtask : pulse
  task automatic t_loop();
    u_host.wr(8'h05, 8'h01);
    rdc(8'h05, 8'h01, "loop mask");
    pulse(4'h0, 4'h0, 1'b1, 1'b1);
    rdc(8'h03, 8'h01, "holdover only");
    `CHK("irq set", 1'b1, irq)
    rdc(8'h03, 8'h00, "loop cleared");
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("irq fall", 1'b0, irq)
    u_host.wr(8'h05, 8'h02);
    pulse(4'h0, 4'h0, 1'b1, 1'b1);
    rdc(8'h03, 8'h02, "unlock only");
  endtask : t_loop
  task automatic t_ref();
    u_host.wr(8'h04, 8'h03);
    rdc(8'h04, 8'h03, "ref mask");
    pulse(4'h2, 4'h0, 1'b0, 1'b0);
    rdc(8'h07, 8'h04, "raw rough0");
    rdc(8'h02, 8'h01, "ref0 status");
    pulse(4'h0, 4'h4, 1'b0, 1'b0);
    rdc(8'h07, 8'h20, "raw single1");
    rdc(8'h02, 8'h02, "ref1 status");
    pulse(4'h1, 4'h1, 1'b0, 1'b0);
    rdc(8'h07, 8'h88, "raw soak");
    rdc(8'h02, 8'h00, "soak filtered");
    u_host.wr(8'h04, 8'h00);
    pulse(4'h2, 4'h2, 1'b0, 1'b0);
    rdc(8'h07, 8'h44, "raw unmasked");
    rdc(8'h02, 8'h00, "ref masked");
    rdc(8'h00, {1'b1, REV, PART}, "id late");
  endtask : t_ref
  task automatic t_gpio(input logic [6:0] p, input logic [7:0] e);
    gpio_in <= p;
    d = 8'h00;
    for (int i = 0; i < 12 && d === 8'h00; i++) u_host.rd(8'h07, d);
    if (d === 8'h00) begin
      miscompares++;
      end_sim();
    end
    `CHK("pin absent", e, d)
    gpio_in <= 7'h00;
    // let the pin synchroniser drain before the clearing read
    repeat (8) @(posedge ref_clk);
    u_host.rd(8'h07, d);
  endtask : t_gpio
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    u_host.settle();
    rdc(8'h00, {1'b1, REV, PART}, "identity");
    rdc(8'hC6, 8'h03, "revision high");
    rdc(8'h01, 8'h00, "unmapped");
    rdc(8'h09, 8'h66, "ind mask");
    rdc(8'hE8, 8'h10, "pin select");
    t_loop();
    t_ref();
    t_gpio(7'h01, 8'h01);
    u_host.wr(8'hE8, 8'h12);
    rdc(8'hE8, 8'h12, "pin select set");
    t_gpio(7'h06, 8'h11);
    end_sim();
  end
endmodule : tb
bind clock_gen_event_status_regs status_regs_chk #(.CLK_HZ(CLK_HZ),
  .PART_CODE(PART_CODE), .REV_LOW(REV_LOW)) u_chk (.ref_clk, .rstn,
  .reg_req, .reg_rdata, .input0_mon, .input1_mon, .loop_holdover,
  .loop_unlock_event, .irq);
`default_nettype wire
